// File: hdl/apcs_consts.svh
// Register offsets, field positions and reset values for port clocking
`ifndef APCS_CONSTS_SVH
`define APCS_CONSTS_SVH
// Register offsets
`define APCS_ADDR_A_SETUP 16'h0200
`define APCS_ADDR_A_RATIO 16'h0201
`define APCS_ADDR_B_SETUP 16'h0204
`define APCS_ADDR_STATUS 16'h0205
// Setup register fields
`define APCS_SRC_MSB 4
`define APCS_SRC_LSB 3
`define APCS_INV_BIT 2
`define APCS_HALVE_BIT 1
`define APCS_ENA_BIT 0
// Rate ratio register fields
`define APCS_IN_DIV_MSB 5
`define APCS_IN_DIV_LSB 3
`define APCS_OUT_DIV_MSB 2
`define APCS_OUT_DIV_LSB 0
// Reset values and special codes
`define APCS_SETUP_RST 5'h00
`define APCS_DIV_RST 3'h0
`define APCS_DIV_RESERVED 3'h7
`define APCS_RDATA_IDLE 16'h0000
`endif

// File: hdl/apcs_pkg.sv
// Types shared by the port clocking design
package apcs_pkg;
  // Clock source codes
  typedef enum logic [1:0] {
    SRC_MASTER_ONE = 2'h0,
    SRC_MASTER_TWO = 2'h1,
    SRC_LOOP_ONE = 2'h2,
    SRC_LOOP_TWO = 2'h3
  } apcs_src_t;
  // Glitch-free switch sequencer states
  typedef enum logic [3:0] {
    APCS_RUN = 4'h1,
    APCS_STOP = 4'h2,
    APCS_LOAD = 4'h4,
    APCS_ARM = 4'h8
  } apcs_state_t;
endpackage

// File: hdl/apcs_port_if.sv
// Carrier between register block and one port clock path
`timescale 1ns/10ps
interface apcs_port_if;
  import apcs_pkg::*;
  apcs_src_t source; // Requested source
  logic invert; // Requested polarity
  logic halve; // Requested divide by two
  logic enable; // Requested gate state
  logic [3:0] src_sync; // Synchronised sources
  logic running; // Gate open
  logic port_clock; // Generated port clock
  modport ctrl (output source, invert, halve, enable, src_sync,
                input running, port_clock);
  modport port (input source, invert, halve, enable, src_sync,
                output running, port_clock);
endinterface

// File: hdl/apcs_port_clk.sv
// One port clock path: select, invert, halve, gate without runts
`timescale 1ns/10ps
`include "apcs_consts.svh"
module apcs_port_clk
  import apcs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control and status carrier
  apcs_port_if.port pif
);
  apcs_state_t state; // Switch sequencer
  apcs_state_t next_state;
  apcs_src_t act_src; // Settings in force
  logic act_inv;
  logic act_halve;
  logic act_ena;
  logic raw; // Selected source after polarity
  logic raw_q; // Previous sample of raw
  logic half; // Divide-by-two toggle
  logic pre; // Clock ahead of the gate
  logic gate; // Output gate
  logic changed; // Request differs from settings in force

  // Selection first, then polarity
  assign raw = pif.src_sync[act_src] ^ act_inv; // [R1] [R2] [R5] [R6]
  // Halving after polarity
  assign pre = act_halve ? half : raw_q; // [R3] [R7] [R12]
  assign changed = {pif.source, pif.invert, pif.halve, pif.enable} !=
                   {act_src, act_inv, act_halve, act_ena};
  assign pif.running = gate;

  // Sample history
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      raw_q <= 1'b0;
    end else begin
      raw_q <= raw;
    end
  end

  // Halving toggle, restarted on each settings load
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      half <= 1'b0;
    end else if (state == APCS_LOAD) begin
      half <= 1'b0;
    end else if (raw && !raw_q) begin
      half <= ~half; // [R3] [R7]
    end
  end

  // Sequencer next state; a stalled-high pre-gate clock holds STOP while the gate is open
  always_comb begin
    next_state = state;
    case (state)
      APCS_RUN: if (changed) next_state = APCS_STOP;
      APCS_STOP: if (!pre || !gate) next_state = APCS_LOAD;
      APCS_LOAD: next_state = APCS_ARM;
      APCS_ARM: if (!act_ena || (!raw && !pre)) next_state = APCS_RUN;
      default: next_state = APCS_RUN;
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= APCS_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Settings take effect only with the gate closed
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      act_src <= SRC_MASTER_ONE;
      act_inv <= 1'b0;
      act_halve <= 1'b0;
      act_ena <= 1'b0;
    end else if (state == APCS_LOAD) begin
      act_src <= pif.source;
      act_inv <= pif.invert;
      act_halve <= pif.halve;
      act_ena <= pif.enable;
    end
  end

  // Gate moves only while the pre-gate clock is low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gate <= 1'b0;
    end else if (state == APCS_STOP && next_state == APCS_LOAD) begin
      gate <= 1'b0; // [R12]
    end else if (state == APCS_ARM && next_state == APCS_RUN) begin
      gate <= act_ena; // [R4] [R8]
    end
  end

  // Registered port clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pif.port_clock <= 1'b0;
    end else begin
      pif.port_clock <= gate & pre; // [R4] [R8] [R12]
    end
  end

  // Gate never moves with the clock high
  property p_gate_quiet; // [R12]
    @(posedge clk) disable iff (sys_rst)
      $changed(gate) |-> $past(pre) == 1'b0;
  endproperty
  a_gate_quiet: assert property (p_gate_quiet) // [R12]
    else $error("gate moved high");

  // Closed gate forces a low clock
  property p_gate_off; // [R4] [R8]
    @(posedge clk) disable iff (sys_rst)
      !gate |=> !pif.port_clock;
  endproperty
  a_gate_off: assert property (p_gate_off) // [R4] [R8]
    else $error("clock leaks");

  // Unhalved clock follows selected source two cycles on
  property p_follow; // [R1] [R2] [R5] [R6]
    @(posedge clk) disable iff (sys_rst)
      (state == APCS_RUN && !act_halve && gate) ##1 (gate && !act_halve)
        |=> pif.port_clock == $past(raw, 2);
  endproperty
  a_follow: assert property (p_follow) // [R1] [R2] [R5] [R6]
    else $error("source mismatch");

  // Halving toggle moves only on a source rise while in RUN
  property p_halve; // [R3] [R7]
    @(posedge clk) disable iff (sys_rst)
      (state == APCS_RUN && $changed(half)) |-> $past(raw && !raw_q);
  endproperty
  a_halve: assert property (p_halve) // [R3] [R7]
    else $error("halve toggled");
endmodule // apcs_port_clk

// File: hdl/apcs_top.sv
// Top: control registers and clock generation for both audio ports
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`include "apcs_consts.svh"
// Operation
// [R1] Port A source bits 4:3, reset 00
// [R2] Port A invert bit 2, reset 0
// [R3] Port A halve bit 1, reset 0
// [R4] Port A enable bit 0, reset off
// [R5] Port B source bits 4:3, reset 00
// [R6] Port B invert bit 2, reset 0
// [R7] Port B halve bit 1, reset 0
// [R8] Port B enable bit 0, reset off
// [R9] Input rate divider bits 5:3, 111 reserved
// [R10] Output rate divider bits 2:0, 111 reserved
// [R11] Both rate dividers reset to 000
// [R12] Select, invert, halve, gate; no runt pulses
module apcs_top
  import apcs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // Clock source pins
  input wire logic master_clock_in_one,
  input wire logic master_clock_in_two,
  input wire logic locked_loop_one_output,
  input wire logic locked_loop_two_output,
  // Generated port clocks
  output logic port_a_clock,
  output logic port_b_clock,
  // Port A rate ratio settings
  output logic [2:0] port_a_input_rate_divider,
  output logic [2:0] port_a_output_rate_divider
);
  // Raw source pins, index equals source code
  logic [3:0] src_pin;
  // First synchroniser stage, read only by the second
  logic [3:0] src_meta;
  // Second synchroniser stage, safe to use
  logic [3:0] src_sync;
  // Setup registers, index 0 is port A
  logic [4:0] setup [2];
  // Rate ratio fields
  logic [2:0] in_div;
  logic [2:0] out_div;
  // Carriers to the two clock paths
  apcs_port_if pif [2] ();
  // Gate status of both paths
  logic [1:0] running;

  // Pins gathered in source code order
  assign src_pin = {locked_loop_two_output, locked_loop_one_output,
                    master_clock_in_two, master_clock_in_one};

  // Two-stage synchroniser per source pin.
  // Sources are far slower than clk here; a source near clk/2
  // would alias, so this path suits low-rate clocks only.
  generate
    for (genvar s = 0; s < 4; s++) begin : g_sync
      // Both stages share one process
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          src_meta[s] <= 1'b0;
          src_sync[s] <= 1'b0;
        end else begin
          src_meta[s] <= src_pin[s];
          src_sync[s] <= src_meta[s];
        end
      end
    end
  endgenerate

  // Setup registers and clock paths, one per port
  generate
    for (genvar g = 0; g < 2; g++) begin : g_port
      // Offset of this port's setup register
      localparam logic [15:0] SETUP_ADDR =
        (g == 0) ? `APCS_ADDR_A_SETUP : `APCS_ADDR_B_SETUP;

      // Setup register write; fields change in the path only
      // once its sequencer has closed the gate
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          setup[g] <= `APCS_SETUP_RST; // [R1] [R4] [R5] [R8]
        end else if (reg_write && reg_addr == SETUP_ADDR) begin
          setup[g] <= reg_wdata[`APCS_SRC_MSB:0];
        end
      end

      // Requested settings onto the carrier
      assign pif[g].source =
        apcs_src_t'(setup[g][`APCS_SRC_MSB:`APCS_SRC_LSB]);
      assign pif[g].invert = setup[g][`APCS_INV_BIT];
      assign pif[g].halve = setup[g][`APCS_HALVE_BIT];
      assign pif[g].enable = setup[g][`APCS_ENA_BIT];
      // Both paths see the same synchronised sources
      assign pif[g].src_sync = src_sync;
      // Gate status for the status register
      assign running[g] = pif[g].running;

      // Clock path for this port
      apcs_port_clk i_apcs_port_clk (
        .clk(clk),
        .sys_rst(sys_rst),
        .pif(pif[g])
      );
    end
  endgenerate

  // Rate ratio register; a reserved code leaves the field as it
  // was, so the rate paths never see an undefined ratio
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_div <= `APCS_DIV_RST; // [R11]
      out_div <= `APCS_DIV_RST; // [R11]
    end else if (reg_write && reg_addr == `APCS_ADDR_A_RATIO) begin
      // Input path field
      if (reg_wdata[`APCS_IN_DIV_MSB:`APCS_IN_DIV_LSB] !=
          `APCS_DIV_RESERVED) begin
        in_div <= reg_wdata[`APCS_IN_DIV_MSB:`APCS_IN_DIV_LSB]; // [R9]
      end
      // Output path field
      if (reg_wdata[`APCS_OUT_DIV_MSB:`APCS_OUT_DIV_LSB] !=
          `APCS_DIV_RESERVED) begin
        out_div <= reg_wdata[`APCS_OUT_DIV_MSB:`APCS_OUT_DIV_LSB]; // [R10]
      end
    end
  end

  // Ratio settings out to the rate paths
  assign port_a_input_rate_divider = in_div;
  assign port_a_output_rate_divider = out_div;

  // Read data, valid only in the cycle after the strobe;
  // idle zero keeps a stale value from looking like an answer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= `APCS_RDATA_IDLE;
    end else if (reg_read) begin
      case (reg_addr)
        // Port A setup
        `APCS_ADDR_A_SETUP: reg_rdata <= {11'h000, setup[0]};
        // Port A rate ratio
        `APCS_ADDR_A_RATIO: reg_rdata <= {10'h000, in_div, out_div};
        // Port B setup
        `APCS_ADDR_B_SETUP: reg_rdata <= {11'h000, setup[1]};
        // Gate status of both ports
        `APCS_ADDR_STATUS: reg_rdata <= {14'h0000, running};
        // Unmapped offsets read zero
        default: reg_rdata <= `APCS_RDATA_IDLE;
      endcase
    end else begin
      reg_rdata <= `APCS_RDATA_IDLE;
    end
  end

  // Port clocks come straight from the path flops
  assign port_a_clock = pif[0].port_clock;
  assign port_b_clock = pif[1].port_clock;

  // Port A source write reaches the carrier next cycle
  property p_a_src; // [R1]
    @(posedge clk) disable iff (sys_rst)
      (reg_write && reg_addr == `APCS_ADDR_A_SETUP)
        |=> pif[0].source == $past(reg_wdata[4:3]);
  endproperty
  a_a_src: assert property (p_a_src) // [R1]
    else $error("A source lost");

  // Port A invert write reaches the carrier
  property p_a_inv; // [R2]
    @(posedge clk) disable iff (sys_rst)
      (reg_write && reg_addr == `APCS_ADDR_A_SETUP)
        |=> pif[0].invert == $past(reg_wdata[2]);
  endproperty
  a_a_inv: assert property (p_a_inv) // [R2]
    else $error("A invert lost");

  // Port A halve write reaches the carrier
  property p_a_halve; // [R3]
    @(posedge clk) disable iff (sys_rst)
      (reg_write && reg_addr == `APCS_ADDR_A_SETUP)
        |=> pif[0].halve == $past(reg_wdata[1]);
  endproperty
  a_a_halve: assert property (p_a_halve) // [R3]
    else $error("A halve lost");

  // Port A held low while its enable stays clear and gate shut
  property p_a_off; // [R4]
    @(posedge clk) disable iff (sys_rst)
      (!pif[0].enable && !running[0]) ##1 !running[0]
        |-> !port_a_clock;
  endproperty
  a_a_off: assert property (p_a_off) // [R4]
    else $error("A clock while off");

  // Port B source write reaches the carrier next cycle
  property p_b_fields; // [R5]
    @(posedge clk) disable iff (sys_rst)
      (reg_write && reg_addr == `APCS_ADDR_B_SETUP)
        |=> pif[1].source == $past(reg_wdata[4:3]);
  endproperty
  a_b_fields: assert property (p_b_fields) // [R5]
    else $error("B source lost");

  // Port B invert write reaches the carrier
  property p_b_inv; // [R6]
    @(posedge clk) disable iff (sys_rst)
      (reg_write && reg_addr == `APCS_ADDR_B_SETUP)
        |=> pif[1].invert == $past(reg_wdata[2]);
  endproperty
  a_b_inv: assert property (p_b_inv) // [R6]
    else $error("B invert lost");

  // Port B halve write reaches the carrier
  property p_b_halve; // [R7]
    @(posedge clk) disable iff (sys_rst)
      (reg_write && reg_addr == `APCS_ADDR_B_SETUP)
        |=> pif[1].halve == $past(reg_wdata[1]);
  endproperty
  a_b_halve: assert property (p_b_halve) // [R7]
    else $error("B halve lost");

  // Port B held low while its enable stays clear and gate shut
  property p_b_off; // [R8]
    @(posedge clk) disable iff (sys_rst)
      (!pif[1].enable && !running[1]) ##1 !running[1]
        |-> !port_b_clock;
  endproperty
  a_b_off: assert property (p_b_off) // [R8]
    else $error("B clock while off");

  // Input divider: valid codes stored, reserved code ignored
  property p_in_div; // [R9]
    @(posedge clk) disable iff (sys_rst)
      (reg_write && reg_addr == `APCS_ADDR_A_RATIO)
        |=> in_div == (($past(reg_wdata[5:3]) == 3'h7) ?
                       $past(in_div) : $past(reg_wdata[5:3]));
  endproperty
  a_in_div: assert property (p_in_div) // [R9]
    else $error("input div wrong");

  // Output divider: valid codes stored, reserved code ignored
  property p_out_div; // [R10]
    @(posedge clk) disable iff (sys_rst)
      (reg_write && reg_addr == `APCS_ADDR_A_RATIO)
        |=> out_div == (($past(reg_wdata[2:0]) == 3'h7) ?
                        $past(out_div) : $past(reg_wdata[2:0]));
  endproperty
  a_out_div: assert property (p_out_div) // [R10]
    else $error("output div wrong");

  // Both dividers zero after reset release
  property p_div_rst; // [R11]
    @(posedge clk) disable iff (sys_rst)
      $fell(sys_rst) |-> (in_div == 3'h0 && out_div == 3'h0);
  endproperty
  a_div_rst: assert property (p_div_rst) // [R11]
    else $error("div reset wrong");

  // Port A enabled from a shut gate stays low while it sequences;
  // STOP, LOAD and ARM must all pass before the gate may open
  property p_a_start; // [R12]
    @(posedge clk) disable iff (sys_rst)
      (reg_write && reg_addr == `APCS_ADDR_A_SETUP && reg_wdata[0]
       && !running[0] && g_port[0].i_apcs_port_clk.state == APCS_RUN)
        |=> (!port_a_clock) [*4];
  endproperty
  a_a_start: assert property (p_a_start) // [R12]
    else $error("A runt at start");

  // Status read returns the gate states
  property p_status;
    @(posedge clk) disable iff (sys_rst)
      (reg_read && reg_addr == `APCS_ADDR_STATUS)
        |=> reg_rdata == {14'h0000, $past(running)};
  endproperty
  a_status: assert property (p_status) else $error("status wrong");

  // Idle cycles with no read strobe return zero
  property p_idle;
    @(posedge clk) disable iff (sys_rst)
      !reg_read |=> reg_rdata == 16'h0000;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");

  // Port A enable write reaches the carrier
  property p_a_ena; // [R4]
    @(posedge clk) disable iff (sys_rst)
      (reg_write && reg_addr == `APCS_ADDR_A_SETUP)
        |=> pif[0].enable == $past(reg_wdata[0]);
  endproperty
  a_a_ena: assert property (p_a_ena) // [R4]
    else $error("A enable lost");

  // Port B enable write reaches the carrier
  property p_b_ena; // [R8]
    @(posedge clk) disable iff (sys_rst)
      (reg_write && reg_addr == `APCS_ADDR_B_SETUP)
        |=> pif[1].enable == $past(reg_wdata[0]);
  endproperty
  a_b_ena: assert property (p_b_ena) // [R8]
    else $error("B enable lost");

  // Port B enabled from a shut gate stays low while it sequences
  property p_b_start; // [R12]
    @(posedge clk) disable iff (sys_rst)
      (reg_write && reg_addr == `APCS_ADDR_B_SETUP && reg_wdata[0]
       && !running[1] && g_port[1].i_apcs_port_clk.state == APCS_RUN)
        |=> (!port_b_clock) [*4];
  endproperty
  a_b_start: assert property (p_b_start) // [R12]
    else $error("B runt at start");

  // Port A setup holds between its writes
  property p_a_hold; // [R1]
    @(posedge clk) disable iff (sys_rst)
      !(reg_write && reg_addr == `APCS_ADDR_A_SETUP)
        |=> $stable(setup[0]);
  endproperty
  a_a_hold: assert property (p_a_hold) // [R1]
    else $error("A setup drifted");

  // Port B setup holds between its writes
  property p_b_hold; // [R5]
    @(posedge clk) disable iff (sys_rst)
      !(reg_write && reg_addr == `APCS_ADDR_B_SETUP)
        |=> $stable(setup[1]);
  endproperty
  a_b_hold: assert property (p_b_hold) // [R5]
    else $error("B setup drifted");

  // Ratio fields hold between ratio writes
  property p_ratio_hold; // [R11]
    @(posedge clk) disable iff (sys_rst)
      !(reg_write && reg_addr == `APCS_ADDR_A_RATIO)
        |=> $stable({in_div, out_div});
  endproperty
  a_ratio_hold: assert property (p_ratio_hold) // [R11]
    else $error("ratio drifted");
endmodule // apcs_top

// File: verif/apcs_top_tb.sv
// Self-checking bench for the port clock select block
`timescale 1ns/10ps
`include "apcs_consts.svh"
module apcs_top_tb
  import apcs_pkg::*;
;
  // Clock and reset
  logic clk;
  logic sys_rst;
  // Register port
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [15:0] reg_rdata;
  // Source pins, half periods 3..6 cycles
  logic [3:0] src = 4'h0;
  int tgl_cnt [4] = '{default: 0};
  // Design outputs
  logic port_a_clock;
  logic port_b_clock;
  logic [2:0] in_div;
  logic [2:0] out_div;
  // Bench bookkeeping
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [31:0] lfsr = 32'h1B40; // Fixed seed keeps runs repeatable
  logic [4:0] exp_a = 5'h00; // Port A setup model
  logic [4:0] exp_b = 5'h00; // Port B setup model
  logic [5:0] exp_ratio = 6'h00; // Ratio model
  logic [15:0] amap [4];
  logic [15:0] corner [4];
  logic [15:0] wd;
  logic [1:0] a_idx;
  // Clock monitor state: source history, then one slot per port
  logic [3:0] hist [0:4];
  logic [1:0] pc;
  logic prev [2];
  int rise [2];
  int high [2];
  int sel [2];
  logic inv;
  logic hv;
  bit lag_on = 1'b0;

  apcs_top i_apcs_top (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .master_clock_in_one(src[0]),
    .master_clock_in_two(src[1]),
    .locked_loop_one_output(src[2]),
    .locked_loop_two_output(src[3]),
    .port_a_clock(port_a_clock),
    .port_b_clock(port_b_clock),
    .port_a_input_rate_divider(in_div),
    .port_a_output_rate_divider(out_div)
  );
  assign pc = {port_b_clock, port_a_clock};

  // Free-running bench clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Slow sources, each well below the sampling rate
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (tgl_cnt[i] >= 2 + i) begin
        tgl_cnt[i] <= 0;
        src[i] <= ~src[i];
      end else begin
        tgl_cnt[i] <= tgl_cnt[i] + 1;
      end
    end
  end

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("unexpected at %0t: timeout", $time);
      test_done;
    end
  end

  // Pseudo-random step
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Ratio register model; code 111 leaves a field alone
  function automatic logic [5:0] ratio_model(input logic [5:0] old,
                                             input logic [15:0] w);
    ratio_model = old;
    if (w[5:3] != 3'h7) ratio_model[5:3] = w[5:3];
    if (w[2:0] != 3'h7) ratio_model[2:0] = w[2:0];
  endfunction

  // Rising edges in a 240-cycle window for a given half period
  function automatic int exp_rises(input int h, input logic halved);
    return 240 / ((halved ? 4 : 2) * h);
  endfunction

  // Compare tasks, one per kind of result
  task automatic check_reg(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: word %h not %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: level %b not %b", $time, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      num_errors++;
      $display("unexpected at %0t: %0d edges not %0d", $time, got, exp);
    end
  endtask

  task automatic check_width(input int w);
    n_tests++;
    if (w < 3) begin
      num_errors++;
      $display("unexpected at %0t: short high pulse %0d", $time, w);
    end
  endtask

  // Port clock monitor: lag match, edge count, pulse width
  always @(negedge clk) begin
    for (int k = 4; k > 0; k--) hist[k] = hist[k-1];
    hist[0] = src;
    for (int p = 0; p < 2; p++) begin
      if (lag_on) check_bit(pc[p], hist[4][sel[p]] ^ inv);
      if (pc[p] === 1'b1 && prev[p] === 1'b0) rise[p]++;
      if (pc[p] === 1'b1) begin
        high[p]++;
      end else begin
        if (high[p] > 0) check_width(high[p]);
        high[p] = 0;
      end
      prev[p] = pc[p];
    end
  end

  // One write cycle
  task automatic reg_wr(input logic [15:0] addr, input logic [15:0] data);
    @(posedge clk);
    reg_addr <= addr;
    reg_wdata <= data;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  // One read cycle; data stands only in the following cycle
  task automatic reg_rd(input logic [15:0] addr, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= addr;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    check_reg(reg_rdata, exp);
    @(negedge clk);
    check_reg(reg_rdata, 16'h0000);
  endtask

  // Read both setups, the ratio and a hole, then the ratio outputs
  task automatic verify_all;
    reg_rd(`APCS_ADDR_A_SETUP, {11'h000, exp_a});
    reg_rd(`APCS_ADDR_B_SETUP, {11'h000, exp_b});
    reg_rd(`APCS_ADDR_A_RATIO, {10'h000, exp_ratio});
    reg_rd(16'h0202, 16'h0000);
    check_reg({10'h000, in_div, out_div}, {10'h000, exp_ratio});
  endtask

  // 240-cycle observation window for both ports
  task automatic window(input int ha, input int hb);
    @(posedge clk);
    rise = '{0, 0};
    lag_on = !hv;
    repeat (240) @(posedge clk);
    lag_on = 1'b0;
    check_count(rise[0], ha);
    check_count(rise[1], hb);
  endtask

  // Verdict and end of run
  task automatic test_done;
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    sys_rst = 1'b1;
    inv = 1'b0;
    hv = 1'b0;
    sel = '{0, 0};
    amap = '{`APCS_ADDR_A_SETUP, `APCS_ADDR_A_RATIO, `APCS_ADDR_B_SETUP,
             16'h0202};
    // Ratio corners: two valid words, both fields reserved, input field reserved
    corner = '{16'h0015, 16'h003F, 16'h0039, 16'hFFF6};
    repeat (20) @(posedge clk);
    check_bit(port_a_clock, 1'b0);
    check_bit(port_b_clock, 1'b0);
    sys_rst <= 1'b0;
    verify_all;
    // Corners first, then random words to random places
    for (int i = 0; i < 28; i++) begin
      lfsr = lfsr_next(lfsr);
      a_idx = (i < 4) ? 2'h1 : lfsr[17:16];
      wd = (i < 4) ? corner[i] : lfsr[15:0];
      reg_wr(amap[a_idx], wd);
      case (a_idx)
        2'h0: exp_a = wd[4:0];
        2'h1: exp_ratio = ratio_model(exp_ratio, wd);
        2'h2: exp_b = wd[4:0];
        default: ; // Hole: nothing stored
      endcase
      verify_all;
    end
    // Every source, polarity and halving on both ports at once
    for (int s = 0; s < 4; s++) begin
      for (int v = 0; v < 4; v++) begin
        inv = v[0];
        hv = v[1];
        sel = '{s, 3 - s};
        reg_wr(`APCS_ADDR_A_SETUP, {11'h000, s[1:0], inv, hv, 1'b1});
        reg_wr(`APCS_ADDR_B_SETUP, {11'h000, 2'h3 - s[1:0], inv, hv, 1'b1});
        repeat (80) @(posedge clk);
        window(exp_rises(3 + s, hv), exp_rises(6 - s, hv));
        // Both gates must report open while their clocks run
        reg_rd(`APCS_ADDR_STATUS, 16'h0003);
      end
    end
    // Gating off must silence both ports
    hv = 1'b1;
    reg_wr(`APCS_ADDR_A_SETUP, 16'h0008);
    reg_wr(`APCS_ADDR_B_SETUP, 16'h0010);
    repeat (80) @(posedge clk);
    window(0, 0);
    check_bit(port_a_clock, 1'b0);
    check_bit(port_b_clock, 1'b0);
    // Both gates must report shut once disabled
    reg_rd(`APCS_ADDR_STATUS, 16'h0000);
    test_done;
  end
endmodule // apcs_top_tb
